// ==== bench/tb_vmb_object_bank.sv ====
/*
  tb_vmb_object_bank: self-checking bench of the velocity-mode object bank.
  assumes the master model for object accesses; core inputs driven here.
*/
`timescale 1ns/1ns
module tb_vmb_object_bank;
  logic REF_CLK, RESET, OBJ_WR, OBJ_RD, OBJ_DONE, HAS_FEEDBACK; // control lines
  logic [1:0] OBJ_ACK;                                           // answer code
  logic [7:0] OBJ_SUB;                                           // sub-index
  logic [15:0] OBJ_INDEX, BASE_CMD, DEMAND_RPM, MEASURED_RPM;    // 16-bit inputs
  logic [15:0] STATUS_IN, STATUS_OUT, CMD_WORD, SPEED_REF;       // status and command
  logic [31:0] OBJ_WDATA, OBJ_RDATA, MIN_SPEED, MAX_SPEED;       // wide values
  logic [15:0] cw[5] = '{16'h0070, 16'h0140, 16'h0040, 16'h0000, 16'h0100}; // bit 4 set first
  logic [4:0]  run = 5'b10100;                                   // run bit per entry, msb first
  logic [15:0] tgt[3] = '{16'hFED4, 16'h01F4, 16'h8000};        // -300, 500, -32768 rpm
  logic [31:0] bad[5] = '{32'h0, 32'h1, 32'h3, 32'hFE, 32'h7F}; // modes other than velocity
  int fail_count = 0;                                            // mismatches seen
  int check_count = 0;                                           // comparisons made
  vmb_object_bank vmb_object_bank_inst (.REF_CLK, .RESET, .OBJ_WR, .OBJ_RD, .OBJ_INDEX, .OBJ_SUB,
    .OBJ_WDATA, .OBJ_RDATA, .OBJ_DONE, .OBJ_ACK, .BASE_CMD, .DEMAND_RPM, .MEASURED_RPM,
    .HAS_FEEDBACK, .STATUS_IN, .STATUS_OUT, .CMD_WORD, .SPEED_REF, .MIN_SPEED, .MAX_SPEED);
  vmb_master_model vmb_master_model_inst (.REF_CLK, .OBJ_DONE, .OBJ_ACK, .OBJ_RDATA, .OBJ_WR,
    .OBJ_RD, .OBJ_INDEX, .OBJ_SUB, .OBJ_WDATA);
  // 125 MHz clock
  initial REF_CLK = 1'b0;
  always #4 REF_CLK = ~REF_CLK;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // write and read wrappers; the answer must come in the very next cycle
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic [1:0] a);
    vmb_master_model_inst.access(1'b1, i, s, d);
    check(32'(vmb_master_model_inst.ack), 32'(a));
    check(32'(vmb_master_model_inst.wait_n), 32'h0);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic [1:0] a);
    vmb_master_model_inst.access(1'b0, i, s, 32'h0);
    check(32'(vmb_master_model_inst.ack), 32'(a));
    check(32'(vmb_master_model_inst.wait_n), 32'h0);
    if (a == 2'd0) check(vmb_master_model_inst.rdata, d); // data only meaningful when accepted
  endtask
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #50000;
    fail_count++;
    finish_test();
  end
  // main sequence
  initial begin
    RESET = 1'b1;
    {BASE_CMD, DEMAND_RPM, MEASURED_RPM, STATUS_IN} = {16'hA5A5, 16'h8123, 16'h0456, 16'hFFFF};
    HAS_FEEDBACK = 1'b1;
    repeat (16) @(posedge REF_CLK);
    #1;
    check({CMD_WORD, SPEED_REF}, 32'h0);
    check(32'(STATUS_OUT), 32'h0000CFFF);
    RESET = 1'b0;
    rd(vmb_pkg::IDX_MODE_SELECT, 8'h00, 32'h2, 2'd0);
    rd(vmb_pkg::IDX_MODE_DISPLAY, 8'h00, 32'h2, 2'd0);
    rd(vmb_pkg::IDX_TARGET_SPEED, 8'h00, 32'h0, 2'd0);
    rd(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_COUNT, 32'h2, 2'd0);
    foreach (bad[k]) wr(vmb_pkg::IDX_MODE_SELECT, 8'h00, bad[k], 2'd3);
    rd(vmb_pkg::IDX_MODE_DISPLAY, 8'h00, 32'h2, 2'd0);
    wr(vmb_pkg::IDX_MODE_SELECT, 8'h00, 32'h2, 2'd0);
    rd(vmb_pkg::IDX_MODE_SELECT, 8'h00, 32'h2, 2'd0);
    // run bit follows ramp enable and halt; bits 4 and 5 change nothing
    foreach (cw[k]) begin
      wr(vmb_pkg::IDX_CONTROL_WORD, 8'h00, {16'h0, cw[k]}, 2'd0);
      @(posedge REF_CLK) #1;
      check(32'(CMD_WORD[0]), 32'(run[4 - k]));
    end
    check(32'(CMD_WORD & 16'hFFFA), 32'(BASE_CMD & 16'hFFFA));
    // sign of the target picks the direction, magnitude is the reference
    foreach (tgt[k]) begin
      wr(vmb_pkg::IDX_TARGET_SPEED, 8'h00, {16'h0, tgt[k]}, 2'd0);
      @(posedge REF_CLK) #1;
      check(32'(CMD_WORD[2]), 32'(tgt[k][15]));
      check(32'(SPEED_REF), 32'(tgt[k][15] ? 16'(-tgt[k]) : tgt[k]));
      rd(vmb_pkg::IDX_TARGET_SPEED, 8'h00, {{16{tgt[k][15]}}, tgt[k]}, 2'd0);
    end
    rd(vmb_pkg::IDX_SPEED_DEMAND, 8'h00, 32'hFFFF8123, 2'd0);
    rd(vmb_pkg::IDX_SPEED_EFFORT, 8'h00, 32'h00000456, 2'd0);
    HAS_FEEDBACK = 1'b0;
    rd(vmb_pkg::IDX_SPEED_EFFORT, 8'h00, 32'hFFFF8123, 2'd0);
    wr(vmb_pkg::IDX_SPEED_DEMAND, 8'h00, 32'h5, 2'd2);
    wr(vmb_pkg::IDX_SPEED_EFFORT, 8'h00, 32'h5, 2'd2);
    wr(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_COUNT, 32'h5, 2'd2);
    rd(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_COUNT, 32'h2, 2'd0);
    wr(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MIN, 32'd100, 2'd0);
    wr(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MAX, 32'd1500, 2'd0);
    wr(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MIN, 32'h0, 2'd3);
    wr(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MAX, 32'h80000000, 2'd3);
    rd(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MIN, 32'd100, 2'd0);
    rd(vmb_pkg::IDX_SPEED_LIMITS, vmb_pkg::SUB_MAX, 32'd1500, 2'd0);
    check({MIN_SPEED[15:0], MAX_SPEED[15:0]}, {16'd100, 16'd1500});
    rd(vmb_pkg::IDX_SPEED_LIMITS, 8'h03, 32'h0, 2'd1);
    wr(16'h6047, 8'h00, 32'h0, 2'd1);
    STATUS_IN = 16'h3000;
    #1 check(32'(STATUS_OUT), 32'h0000_0000);
    // second reset in mid-run returns the defaults
    RESET = 1'b1;
    @(posedge REF_CLK) #1;
    check({CMD_WORD, SPEED_REF}, 32'h0000_0000);
    check(MIN_SPEED, 32'h0000_0000);
    check(MAX_SPEED, 32'h0000_0000);
    RESET = 1'b0;
    rd(vmb_pkg::IDX_TARGET_SPEED, 8'h00, 32'h0, 2'd0);
    rd(vmb_pkg::IDX_MODE_DISPLAY, 8'h00, 32'h2, 2'd0);
    finish_test();
  end
endmodule

// ==== bench/vmb_master_model.sv ====
/*
  vmb_master_model: network master issuing one object access at a time.
  assumes a bank that takes the strobe on a rising edge and answers one cycle later.
*/
`timescale 1ns/1ns
module vmb_master_model (
  input  wire logic        REF_CLK,   // system clock
  input  wire logic        OBJ_DONE,  // answer strobe
  input  wire logic [1:0]  OBJ_ACK,   // answer code
  input  wire logic [31:0] OBJ_RDATA, // read data
  output logic             OBJ_WR,    // write strobe
  output logic             OBJ_RD,    // read strobe
  output logic      [15:0] OBJ_INDEX, // object index
  output logic      [7:0]  OBJ_SUB,   // sub-index
  output logic      [31:0] OBJ_WDATA  // write data
);
  logic [31:0] rdata;  // data of the last answer
  logic [1:0]  ack;    // code of the last answer
  int          wait_n; // cycles waited past the answer slot
  initial begin
    {OBJ_WR, OBJ_RD, OBJ_INDEX, OBJ_SUB, OBJ_WDATA} = '0;
  end
  // strobe stands for exactly one taking edge; lines are inverted afterwards
  // so the bank can never profit from a stale index or data value
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    @(posedge REF_CLK) #1;
    {OBJ_WR, OBJ_RD, OBJ_INDEX, OBJ_SUB, OBJ_WDATA} = {wr, ~wr, idx, sub, d};
    @(posedge REF_CLK) #1;
    {OBJ_WR, OBJ_RD, OBJ_INDEX, OBJ_SUB, OBJ_WDATA} = {2'b00, ~idx, ~sub, ~d};
    for (wait_n = 0; wait_n < 4 && OBJ_DONE !== 1'b1; wait_n++) @(posedge REF_CLK) #1;
    rdata = OBJ_RDATA;
    ack   = OBJ_ACK;
  endtask
endmodule

// ==== logic/vmb_cmd_map.sv ====
/*
  vmb_cmd_map: maps the control word and target speed onto the internal
  command word and the unsigned speed reference.
  assumes control word and target speed come from registers of the bank.
*/
`timescale 1ns/1ns
module vmb_cmd_map (
  input  wire logic [15:0] ctrl_word,    // control word as held by the bank
  input  wire logic [15:0] target_speed, // signed target speed in rpm
  input  wire logic [15:0] base_cmd,     // state-machine bits from outside
  output logic      [15:0] cmd_word,     // internal command word
  output logic      [15:0] speed_mag     // speed reference magnitude
);
  logic run_req; // ramp run request

  // run needs ramp enabled and no halt; bits 4 and 5 have no effect here
  always_comb begin
    run_req  = ctrl_word[vmb_pkg::CW_RAMP_BIT] & ~ctrl_word[vmb_pkg::CW_HALT_BIT];
    cmd_word = base_cmd;
    cmd_word[vmb_pkg::ICW_RUN_BIT] = run_req;
    cmd_word[vmb_pkg::ICW_REV_BIT] = target_speed[15];
    // magnitude only; direction travels in the command word
    if (target_speed[15]) begin
      speed_mag = 16'(~target_speed + 16'h0001);
    end else begin
      speed_mag = target_speed;
    end
  end
endmodule

// ==== logic/vmb_object_bank.sv ====
/*
  vmb_object_bank: velocity-mode object bank of the drive's network side.
  holds mode select/display, target speed, demand, effort and speed limits,
  and forms the internal command word and speed reference.
  assumes an object access port (index, sub-index, strobes) from the
  protocol stack and ramp/measurement values from the drive core.
*/
// Functional notes
// - mode select supports only velocity value 2
// - mode display reports same encoding, reads 2
// - control bit 6 enables ramp run bit
// - control bit 8 halts, clearing run bit
// - control bits 4 and 5 have no function
// - status bits 12 and 13 stay reserved
// - target speed signed 16-bit, reset zero
// - negative target sets reverse command bit 2
// - demand object shows post-ramp reference
// - effort shows measured speed, or demand
// - limit array sub 0 reads 2; 1,2 writable
// - limits positive only, both directions
// - run bit 0 starts/stops through ramp
`timescale 1ns/1ns
module vmb_object_bank (
  input  wire logic        REF_CLK,      // system clock, 125 MHz
  input  wire logic        RESET,        // asynchronous reset, active high
  input  wire logic        OBJ_WR,       // write strobe, one cycle
  input  wire logic        OBJ_RD,       // read strobe, one cycle
  input  wire logic [15:0] OBJ_INDEX,    // object index
  input  wire logic [7:0]  OBJ_SUB,      // object sub-index
  input  wire logic [31:0] OBJ_WDATA,    // write data, all 32 bits for limits, low bits otherwise
  output logic      [31:0] OBJ_RDATA,    // read data, registered
  output logic             OBJ_DONE,     // answer strobe, registered
  output logic      [1:0]  OBJ_ACK,      // answer code, registered
  input  wire logic [15:0] BASE_CMD,     // state-machine command bits
  input  wire logic [15:0] DEMAND_RPM,   // ramp output from drive core
  input  wire logic [15:0] MEASURED_RPM, // measured motor speed
  input  wire logic        HAS_FEEDBACK, // measured speed is valid
  input  wire logic [15:0] STATUS_IN,    // status word from state machine
  output logic      [15:0] STATUS_OUT,   // status word, mode bits cleared
  output logic      [15:0] CMD_WORD,     // internal network command word
  output logic      [15:0] SPEED_REF,    // internal speed reference
  output logic      [31:0] MIN_SPEED,    // internal minimum speed setting
  output logic      [31:0] MAX_SPEED     // internal maximum speed setting
);
  // full state of the bank
  typedef struct packed {
    logic [15:0] ctrl;     // control word copy
    logic [15:0] target;   // target speed
    logic [31:0] vmin;     // minimum speed
    logic [31:0] vmax;     // maximum speed
    logic [7:0]  mode;     // active mode
    logic [31:0] rdata;    // read answer data
    logic        done;     // answer strobe
    logic [1:0]  ack;      // answer code
    logic [15:0] cmd;      // command word out
    logic [15:0] sref;     // speed reference out
  } vmb_state_t;

  vmb_state_t   st_r;        // registered state
  vmb_state_t   st_nxt;      // next state
  logic [15:0]  cmd_w;       // mapped command word
  logic [15:0]  mag_w;       // speed magnitude
  logic [15:0]  effort_w;    // effort object value
  vmb_pkg::vmb_ack_t ack_w;  // answer for current access

  // sign-extend a 16-bit object into the 32-bit read word
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // a speed limit is accepted only when strictly positive
  function automatic logic limit_ok(input logic [31:0] v);
    limit_ok = (v != 32'h0000_0000) && !v[31];
  endfunction

  vmb_cmd_map vmb_cmd_map_inst (
    .ctrl_word    (st_r.ctrl),
    .target_speed (st_r.target),
    .base_cmd     (BASE_CMD),
    .cmd_word     (cmd_w),
    .speed_mag    (mag_w)
  );

  // without feedback the effort mirrors the demand
  assign effort_w = HAS_FEEDBACK ? MEASURED_RPM : DEMAND_RPM;

  // object decode, write acceptance and read mux
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    ack_w       = vmb_pkg::VMB_ACK_OK;
    st_nxt.cmd  = cmd_w;   // registered so outputs are glitch free
    st_nxt.sref = mag_w;
    if (OBJ_WR || OBJ_RD) begin
      st_nxt.rdata = 32'h0000_0000;
      case (OBJ_INDEX)
        vmb_pkg::IDX_CONTROL_WORD: begin
          if (OBJ_WR) st_nxt.ctrl = OBJ_WDATA[15:0];
          else st_nxt.rdata = {16'h0000, st_r.ctrl};
        end
        vmb_pkg::IDX_TARGET_SPEED: begin
          if (OBJ_WR) st_nxt.target = OBJ_WDATA[15:0];
          else st_nxt.rdata = sext16(st_r.target);
        end
        vmb_pkg::IDX_SPEED_DEMAND: begin
          if (OBJ_WR) ack_w = vmb_pkg::VMB_ACK_READ_ONLY;
          else st_nxt.rdata = sext16(DEMAND_RPM);
        end
        vmb_pkg::IDX_SPEED_EFFORT: begin
          if (OBJ_WR) ack_w = vmb_pkg::VMB_ACK_READ_ONLY;
          else st_nxt.rdata = sext16(effort_w);
        end
        vmb_pkg::IDX_SPEED_LIMITS: begin
          case (OBJ_SUB)
            vmb_pkg::SUB_COUNT: begin
              if (OBJ_WR) ack_w = vmb_pkg::VMB_ACK_READ_ONLY;
              else st_nxt.rdata = vmb_pkg::LIMIT_SUB_LAST;
            end
            vmb_pkg::SUB_MIN: begin
              if (!OBJ_WR) st_nxt.rdata = st_r.vmin;
              else if (limit_ok(OBJ_WDATA)) st_nxt.vmin = OBJ_WDATA;
              else ack_w = vmb_pkg::VMB_ACK_BAD_VALUE;
            end
            vmb_pkg::SUB_MAX: begin
              if (!OBJ_WR) st_nxt.rdata = st_r.vmax;
              else if (limit_ok(OBJ_WDATA)) st_nxt.vmax = OBJ_WDATA;
              else ack_w = vmb_pkg::VMB_ACK_BAD_VALUE;
            end
            default: ack_w = vmb_pkg::VMB_ACK_NO_OBJECT;
          endcase
        end
        vmb_pkg::IDX_MODE_SELECT, vmb_pkg::IDX_MODE_DISPLAY: begin
          // display is writable too but only the one mode is accepted
          if (!OBJ_WR) st_nxt.rdata = sext16({{8{st_r.mode[7]}}, st_r.mode});
          else if (OBJ_WDATA[7:0] == vmb_pkg::MODE_VELOCITY) st_nxt.mode = OBJ_WDATA[7:0];
          else ack_w = vmb_pkg::VMB_ACK_BAD_VALUE;
        end
        default: ack_w = vmb_pkg::VMB_ACK_NO_OBJECT;
      endcase
      st_nxt.done = 1'b1;
      st_nxt.ack  = ack_w;
    end
  end

  // state register; mode starts in the only supported mode
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      st_r.ctrl   <= vmb_pkg::CONTROL_WORD_RST;
      st_r.target <= vmb_pkg::TARGET_SPEED_RST;
      st_r.vmin   <= vmb_pkg::MIN_SPEED_RST;
      st_r.vmax   <= vmb_pkg::MAX_SPEED_RST;
      st_r.mode   <= vmb_pkg::MODE_VELOCITY;
      st_r.rdata  <= 32'h0000_0000;
      st_r.done   <= 1'b0;
      st_r.ack    <= 2'h0;
      st_r.cmd    <= 16'h0000;
      st_r.sref   <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign OBJ_RDATA = st_r.rdata;
  assign OBJ_DONE  = st_r.done;
  assign OBJ_ACK   = st_r.ack;
  assign CMD_WORD  = st_r.cmd;
  assign SPEED_REF = st_r.sref;
  assign MIN_SPEED = st_r.vmin;
  assign MAX_SPEED = st_r.vmax;
  // mode-specific status bits are held at zero for now
  always_comb begin
    STATUS_OUT = STATUS_IN;
    STATUS_OUT[vmb_pkg::SW_MS_LO_BIT] = 1'b0;
    STATUS_OUT[vmb_pkg::SW_MS_HI_BIT] = 1'b0;
  end

  // assertions
  a_mode_fixed: assert property (@(posedge REF_CLK) disable iff (RESET)
    st_r.mode == vmb_pkg::MODE_VELOCITY) else $error("mode left velocity");
  a_bad_mode_nack: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_MODE_SELECT && OBJ_WDATA[7:0] != vmb_pkg::MODE_VELOCITY
    |=> OBJ_DONE && OBJ_ACK == 2'(vmb_pkg::VMB_ACK_BAD_VALUE)) else $error("bad mode accepted");
  a_mode_readback: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_RD && OBJ_INDEX == vmb_pkg::IDX_MODE_DISPLAY |=> OBJ_RDATA == 32'h0000_0002)
    else $error("mode display wrong");
  a_run_bit: assert property (@(posedge REF_CLK) disable iff (RESET)
    ##1 CMD_WORD[0] == ($past(st_r.ctrl[6]) && !$past(st_r.ctrl[8]))) else $error("run bit wrong");
  a_halt_stops: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_CONTROL_WORD && OBJ_WDATA[8] |=> ##1 !CMD_WORD[0])
    else $error("halt ignored");
  a_reverse_bit: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_TARGET_SPEED |=> ##1 CMD_WORD[2] == $past(OBJ_WDATA[15], 2))
    else $error("direction bit wrong");
  a_demand_read: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_RD && OBJ_INDEX == vmb_pkg::IDX_SPEED_DEMAND |=> OBJ_RDATA[15:0] == $past(DEMAND_RPM))
    else $error("demand read wrong");
  a_effort_mirror: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_RD && OBJ_INDEX == vmb_pkg::IDX_SPEED_EFFORT && !HAS_FEEDBACK
    |=> OBJ_RDATA[15:0] == $past(DEMAND_RPM)) else $error("effort not demand");
  a_limit_count: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_RD && OBJ_INDEX == vmb_pkg::IDX_SPEED_LIMITS && OBJ_SUB == 8'h00 |=> OBJ_RDATA == 32'h0000_0002)
    else $error("limit count wrong");
  a_limit_positive: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_SPEED_LIMITS && OBJ_SUB == 8'h02 && OBJ_WDATA[31]
    |=> $stable(MAX_SPEED)) else $error("negative limit taken");
  a_status_rsvd: assert property (@(posedge REF_CLK) disable iff (RESET)
    STATUS_OUT[13:12] == 2'h0) else $error("status mode bits set");
  // a clean ramp-enable write must raise the run bit two edges later
  a_ramp_start: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_CONTROL_WORD
    && OBJ_WDATA[vmb_pkg::CW_RAMP_BIT] && !OBJ_WDATA[vmb_pkg::CW_HALT_BIT]
    |=> ##1 CMD_WORD[vmb_pkg::ICW_RUN_BIT]) else $error("ramp start ignored");
  a_min_guarded: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_SPEED_LIMITS && OBJ_SUB == vmb_pkg::SUB_MIN
    && (OBJ_WDATA == 32'h0000_0000 || OBJ_WDATA[31])
    |=> $stable(MIN_SPEED) && OBJ_ACK == 2'(vmb_pkg::VMB_ACK_BAD_VALUE)) else $error("bad minimum taken");
  a_effort_measured: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_RD && !OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_SPEED_EFFORT && HAS_FEEDBACK
    |=> OBJ_RDATA[15:0] == $past(MEASURED_RPM)) else $error("effort not measured");
  a_sub0_fixed: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_SPEED_LIMITS && OBJ_SUB == vmb_pkg::SUB_COUNT
    |=> OBJ_DONE && OBJ_ACK == 2'(vmb_pkg::VMB_ACK_READ_ONLY)) else $error("limit count writable");
  a_mode_accept: assert property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_WR && OBJ_INDEX == vmb_pkg::IDX_MODE_SELECT && OBJ_WDATA[7:0] == vmb_pkg::MODE_VELOCITY
    |=> OBJ_DONE && OBJ_ACK == 2'(vmb_pkg::VMB_ACK_OK)) else $error("velocity mode refused");
  // main scenarios: run, reverse, refused mode, halt, sensorless effort
  c_run: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(CMD_WORD[0]));
  c_reverse: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(CMD_WORD[2]));
  c_bad_mode: cover property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_DONE && OBJ_ACK == 2'(vmb_pkg::VMB_ACK_BAD_VALUE));
  c_halt: cover property (@(posedge REF_CLK) disable iff (RESET) $fell(CMD_WORD[0]));
  c_no_feedback: cover property (@(posedge REF_CLK) disable iff (RESET)
    OBJ_DONE && !HAS_FEEDBACK);
endmodule

// ==== pkg/vmb_pkg.sv ====
/*
  package for the velocity-mode object bank: object indices, sub-indices,
  field positions, reset values and the access response codes.
  assumes a single system clock domain; no other package is needed.
*/
package vmb_pkg;
  // object dictionary indices
  localparam logic [15:0] IDX_CONTROL_WORD   = 16'h6040;
  localparam logic [15:0] IDX_TARGET_SPEED   = 16'h6042;
  localparam logic [15:0] IDX_SPEED_DEMAND   = 16'h6043;
  localparam logic [15:0] IDX_SPEED_EFFORT   = 16'h6044;
  localparam logic [15:0] IDX_SPEED_LIMITS   = 16'h6046;
  localparam logic [15:0] IDX_MODE_SELECT    = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISPLAY   = 16'h6061;
  // sub-indices
  localparam logic [7:0]  SUB_COUNT          = 8'h00;
  localparam logic [7:0]  SUB_MIN            = 8'h01;
  localparam logic [7:0]  SUB_MAX            = 8'h02;
  localparam logic [31:0] LIMIT_SUB_LAST     = 32'h0000_0002;
  // mode encoding
  localparam logic [7:0]  MODE_VELOCITY      = 8'h02;
  // control word bit positions in velocity mode
  localparam int          CW_RSVD4_BIT       = 4;
  localparam int          CW_RSVD5_BIT       = 5;
  localparam int          CW_RAMP_BIT        = 6;
  localparam int          CW_HALT_BIT        = 8;
  // internal command word bit positions
  localparam int          ICW_RUN_BIT        = 0;
  localparam int          ICW_REV_BIT        = 2;
  // status word mode-specific bits
  localparam int          SW_MS_LO_BIT       = 12;
  localparam int          SW_MS_HI_BIT       = 13;
  // reset values
  localparam logic [15:0] TARGET_SPEED_RST   = 16'h0000;
  localparam logic [15:0] CONTROL_WORD_RST   = 16'h0000;
  localparam logic [31:0] MIN_SPEED_RST      = 32'h0000_0000;
  localparam logic [31:0] MAX_SPEED_RST      = 32'h0000_0000;
  // access answer codes
  typedef enum logic [1:0] {
    VMB_ACK_OK,
    VMB_ACK_NO_OBJECT,
    VMB_ACK_READ_ONLY,
    VMB_ACK_BAD_VALUE
  } vmb_ack_t;
endpackage
